// ---- rtl/wwd_windowed_watchdog.sv ----
// How it works
// - Period field picks 03FFh/0FFFh/1FFFh/3FFFh initial count
// - Window field picks 25/50/75/100 percent share
// - Refresh outside window raises interrupt or reset
// - 00h then FFh inside window, reset, underflow reload counter
// - Unprotected mode counts down on CPU clock
// - Prescaler divides 16 or 128, 2 on low-speed
// - Unprotected period is division ratio times count
// - Option bit 1: stopped until start write
// - Option bit 0: starts right after reset
// - Unprotected counter halts in stop and wait
// - Unprotected underflow: action bit picks interrupt/reset
// - Prescaler cleared by reset only
// - Auto-start option is read-only to software
// - Protected mode counts oscillator ticks, no prescaler
// - Protected counter keeps running in stop/wait
// - Protected underflow always resets
// - Protection turns oscillator on, forces reset action
// - Protection-after-reset option sets protection bit
// - Erased option byte two reads FFh
// - Protection set by 0 then 1, never cleared
// - Control register shows six-bit counter slice
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module wwd_windowed_watchdog (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [wwd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [wwd_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wwd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [wwd_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [wwd_pkg::REG_W-1:0] optionByteOneFlash,
  input wire wwd_pkg::wwd_opt2_t watchdogOptionByteTwoFlash,
  input wire logic flashBlank,
  input wire logic wdtOscClk,
  input wire logic stopMode,
  input wire logic waitMode,
  output wwd_pkg::wwd_event_t wdtEvent,
  output logic wdtOscOn
);
  import wwd_pkg::*;

  function automatic wwd_reg_t regSel(input logic [ADDR_W-1:0] addr);
    if (addr == {IDX_REFRESH, 2'b00}) begin
      return WWD_R_REFRESH;
    end else if (addr == {IDX_START, 2'b00}) begin
      return WWD_R_START;
    end else if (addr == {IDX_CONTROL, 2'b00}) begin
      return WWD_R_CONTROL;
    end else if (addr == {IDX_PROTECT, 2'b00}) begin
      return WWD_R_PROTECT;
    end else if (addr == {IDX_PM_ONE, 2'b00}) begin
      return WWD_R_PM_ONE;
    end else if (addr == {IDX_CLK_ZERO, 2'b00}) begin
      return WWD_R_CLK_ZERO;
    end else if (addr == {IDX_OPT_TWO, 2'b00}) begin
      return WWD_R_OPT_TWO;
    end else if (addr == {IDX_OPT_ONE, 2'b00}) begin
      return WWD_R_OPT_ONE;
    end else begin
      return WWD_R_NONE;
    end
  endfunction : regSel

  function automatic logic [CNT_W-1:0] initOf(input logic [1:0] sel);
    case (sel)
      2'b00: return INIT_P0;
      2'b01: return INIT_P1;
      2'b10: return INIT_P2;
      default: return INIT_P3;
    endcase
  endfunction : initOf

  // Count values below this limit lie inside the refresh window
  function automatic logic [CNT_W:0] winLimitOf(input logic [CNT_W-1:0] init, input logic [1:0] sel);
    logic [CNT_W:0] quarter;
    quarter = ({1'b0, init} + {1'b0, CNT_ONE}) >> 2;
    case (sel)
      2'b00: return quarter;
      2'b01: return quarter << 1;
      2'b10: return quarter + (quarter << 1);
      default: return quarter << 2;
    endcase
  endfunction : winLimitOf

  function automatic logic [5:0] ctrlSlice(input logic [CNT_W-1:0] cnt, input logic [1:0] sel);
    case (sel)
      2'b00: return cnt[5:0];
      2'b01: return cnt[7:2];
      2'b10: return cnt[8:3];
      default: return cnt[9:4];
    endcase
  endfunction : ctrlSlice

  logic awHeld;
  logic [ADDR_W-1:0] awAddr;
  logic wHeld;
  logic [REG_W-1:0] wByte;
  logic wLane;
  logic optLoaded;
  logic [REG_W-1:0] optionByteOne;
  wwd_opt2_t watchdogOptionByteTwo;
  wwd_state_t state;
  logic [CNT_W-1:0] count;
  logic [PRE_W-1:0] prescaler;
  logic oscPrev;
  logic refreshArm;
  logic protArm;
  logic protectionModeBit;
  logic underflowActionSelect;
  logic lowSpeedClockSelect;
  logic prescalerSelect;

  logic wrDo;
  wwd_reg_t wrSel;
  logic wrEn;
  logic loadCycle;
  logic [REG_W-1:0] optOneEff;
  wwd_opt2_t optTwoEff;
  logic running;
  logic halted;
  logic [PRE_W-1:0] preMask;
  logic preTick;
  logic oscEdge;
  logic cntTick;
  logic underflow;
  logic refreshDone;
  logic inWindow;
  logic goodRefresh;
  logic badRefresh;
  logic startWrite;
  logic eventIsReset;
  logic wdtFault;
  logic [CNT_W-1:0] initValue;
  logic [REG_W-1:0] rdByte;

  // AXI4-Lite handshakes; address and data are taken in either order
  assign s_axi_awready = ce && !awHeld;
  assign s_axi_wready = ce && !wHeld;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign wrDo = ce && awHeld && wHeld && !s_axi_bvalid;
  assign wrSel = regSel(awAddr);
  assign wrEn = wrDo && wLane;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (wrDo) begin
        awHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wHeld <= 1'b0;
      wByte <= REG_ZERO;
      wLane <= 1'b0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wByte <= s_axi_wdata[REG_W-1:0];
        wLane <= s_axi_wstrb[0];
      end else if (wrDo) begin
        wHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wrDo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrSel == WWD_R_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    case (regSel(s_axi_araddr))
      WWD_R_CONTROL: rdByte = {prescalerSelect, 1'b0, ctrlSlice(count, watchdogOptionByteTwo.periodSel)};
      WWD_R_PROTECT: rdByte = {protectionModeBit, 7'h00};
      WWD_R_PM_ONE: rdByte = {5'h00, underflowActionSelect, 2'h0};
      WWD_R_CLK_ZERO: rdByte = {lowSpeedClockSelect, 7'h00};
      WWD_R_OPT_TWO: rdByte = watchdogOptionByteTwo;
      WWD_R_OPT_ONE: rdByte = optionByteOne;
      default: rdByte = REG_ZERO;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {{(DATA_W-REG_W){1'b0}}, rdByte};
        s_axi_rresp <= (regSel(s_axi_araddr) == WWD_R_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Option bytes come from flash; a blank block reads all ones
  assign optOneEff = flashBlank ? OPT_ERASED : optionByteOneFlash;
  assign optTwoEff = flashBlank ? wwd_opt2_t'(OPT_ERASED) : watchdogOptionByteTwoFlash;
  assign loadCycle = ce && !optLoaded;

  // Captured once after reset release; bus writes never touch them
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      optLoaded <= 1'b0;
      optionByteOne <= OPT_ERASED;
      watchdogOptionByteTwo <= wwd_opt2_t'(OPT_ERASED);
    end else if (loadCycle) begin
      optLoaded <= 1'b1;
      optionByteOne <= optOneEff;
      watchdogOptionByteTwo <= optTwoEff;
    end
  end

  assign startWrite = wrEn && (wrSel == WWD_R_START);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= WWD_STOPPED;
    end else if (ce) begin
      case (state)
        WWD_STOPPED: begin
          if (loadCycle && !optOneEff[AUTOSTART_BIT]) begin
            state <= WWD_RUNNING;
          end else if (startWrite && optLoaded) begin
            state <= WWD_RUNNING;
          end
        end
        default: state <= WWD_RUNNING;
      endcase
    end
  end

  // Control bits held in software registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prescalerSelect <= 1'b0;
      lowSpeedClockSelect <= 1'b0;
    end else if (wrEn) begin
      if (wrSel == WWD_R_CONTROL) begin
        prescalerSelect <= wByte[PRESEL_BIT];
      end else if (wrSel == WWD_R_CLK_ZERO) begin
        lowSpeedClockSelect <= wByte[LSCLK_BIT];
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      protArm <= 1'b0;
      protectionModeBit <= 1'b0;
    end else if (loadCycle) begin
      protectionModeBit <= !optOneEff[PROTINIT_BIT];
    end else if (wrEn && wrSel == WWD_R_PROTECT) begin
      protArm <= !wByte[PROT_BIT];
      if (wByte[PROT_BIT] && protArm) begin
        protectionModeBit <= 1'b1;
      end
    end else if (wrEn) begin
      protArm <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      underflowActionSelect <= 1'b0;
    end else if (ce) begin
      if (protectionModeBit) begin
        underflowActionSelect <= 1'b1;
      end else if (wrEn && wrSel == WWD_R_PM_ONE) begin
        underflowActionSelect <= wByte[ACTION_BIT];
      end
    end
  end

  assign wdtOscOn = protectionModeBit;

  // Count source selection
  assign running = (state == WWD_RUNNING);
  assign halted = !protectionModeBit && (stopMode || waitMode);
  assign preMask = lowSpeedClockSelect ? DIV2_MASK : (prescalerSelect ? DIV128_MASK : DIV16_MASK);
  assign preTick = (prescaler & preMask) == preMask;
  assign oscEdge = wdtOscClk && !oscPrev;
  assign cntTick = ce && running && (protectionModeBit ? oscEdge : (!halted && preTick));
  assign underflow = cntTick && (count == CNT_LAST);

  // Prescaler counts while the unprotected counter runs; only reset clears it, so refresh leaves phase alone
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prescaler <= '0;
    end else if (ce && running && !halted && !protectionModeBit) begin
      prescaler <= prescaler + PRE_ONE;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      oscPrev <= 1'b0;
    end else if (ce) begin
      oscPrev <= wdtOscClk;
    end
  end

  // Refresh sequence: an FFh write completes only right after a 00h write
  assign refreshDone = wrEn && (wrSel == WWD_R_REFRESH) && (wByte == REFRESH_SECOND) && refreshArm;
  assign inWindow = {1'b0, count} < winLimitOf(initValue, watchdogOptionByteTwo.windowSel);
  assign goodRefresh = refreshDone && running && inWindow;
  assign badRefresh = refreshDone && running && !inWindow;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      refreshArm <= 1'b0;
    end else if (wrEn) begin
      refreshArm <= (wrSel == WWD_R_REFRESH) && (wByte == REFRESH_FIRST);
    end
  end

  assign initValue = initOf(watchdogOptionByteTwo.periodSel);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (loadCycle) begin
      count <= initOf(optTwoEff.periodSel);
    end else if (ce) begin
      if ((startWrite && !running) || goodRefresh || underflow) begin
        count <= initValue;
      end else if (cntTick) begin
        count <= count - CNT_ONE;
      end
    end
  end

  // Fault outputs are one-cycle pulses
  assign eventIsReset = underflowActionSelect || protectionModeBit;
  assign wdtFault = underflow || badRefresh;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wdtEvent <= '0;
    end else if (ce) begin
      wdtEvent.irq <= wdtFault && !eventIsReset;
      wdtEvent.rst <= wdtFault && eventIsReset;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_refresh_reload: assert property (goodRefresh && !underflow |=> count == initValue)
    else $error("refresh did not reload counter");
  a_bad_refresh_flag: assert property (badRefresh |=> (wdtEvent.irq || wdtEvent.rst))
    else $error("refresh outside window not flagged");
  a_prot_underflow: assert property (underflow && protectionModeBit |=> wdtEvent.rst && !wdtEvent.irq)
    else $error("protected underflow gave no reset");
  a_unprot_irq: assert property (underflow && !eventIsReset |=> wdtEvent.irq && !wdtEvent.rst)
    else $error("underflow interrupt missing");
  a_prot_sticky: assert property (protectionModeBit |=> protectionModeBit)
    else $error("protection bit cleared");
  a_prot_forces: assert property (ce && protectionModeBit |=> underflowActionSelect && wdtOscOn)
    else $error("protection did not force reset action");
  a_halt_holds: assert property (ce && running && halted && !wrEn |=> $stable(count) && $stable(prescaler))
    else $error("counter moved in stop or wait");
  a_prescale_keep: assert property (ce && goodRefresh && !halted && !protectionModeBit
    |=> prescaler == $past(prescaler) + PRE_ONE)
    else $error("refresh disturbed prescaler");
  a_count_step: assert property (cntTick && !underflow && !wrEn |=> count == $past(count) - CNT_ONE)
    else $error("counter did not decrement");
  a_auto_start: assert property (loadCycle && !optOneEff[AUTOSTART_BIT] |=> running ##1 running)
    else $error("auto start failed");
  a_stay_stopped: assert property (optLoaded && !running && !startWrite |=> !running && $stable(count))
    else $error("counter started without start write");

  c_good_refresh: cover property (goodRefresh);
  c_bad_refresh: cover property (badRefresh);
  c_prot_underflow: cover property (underflow && protectionModeBit);
  c_start_write: cover property (startWrite && !running);
endmodule : wwd_windowed_watchdog
`default_nettype wire

// ---- rtl/wwd_pkg.sv ----
package wwd_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int CNT_W = 14;
  localparam int PRE_W = 7;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_REFRESH = 16'h000D;
  localparam logic [15:0] IDX_START = 16'h000E;
  localparam logic [15:0] IDX_CONTROL = 16'h000F;
  localparam logic [15:0] IDX_PROTECT = 16'h001C;
  localparam logic [15:0] IDX_PM_ONE = 16'h0020;
  localparam logic [15:0] IDX_CLK_ZERO = 16'h0021;
  localparam logic [15:0] IDX_OPT_TWO = 16'hFFDB;
  localparam logic [15:0] IDX_OPT_ONE = 16'hFFFF;
  // Bit positions
  localparam int PRESEL_BIT = 7;
  localparam int PROT_BIT = 7;
  localparam int ACTION_BIT = 2;
  localparam int LSCLK_BIT = 7;
  localparam int AUTOSTART_BIT = 0;
  localparam int PROTINIT_BIT = 7;
  // Values
  localparam logic [REG_W-1:0] REFRESH_FIRST = 8'h00;
  localparam logic [REG_W-1:0] REFRESH_SECOND = 8'hFF;
  localparam logic [REG_W-1:0] OPT_ERASED = 8'hFF;
  localparam logic [REG_W-1:0] REG_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] INIT_P0 = 14'h03FF;
  localparam logic [CNT_W-1:0] INIT_P1 = 14'h0FFF;
  localparam logic [CNT_W-1:0] INIT_P2 = 14'h1FFF;
  localparam logic [CNT_W-1:0] INIT_P3 = 14'h3FFF;
  localparam logic [CNT_W-1:0] CNT_LAST = 14'h0001;
  localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;
  localparam logic [PRE_W-1:0] DIV2_MASK = 7'h01;
  localparam logic [PRE_W-1:0] DIV16_MASK = 7'h0F;
  localparam logic [PRE_W-1:0] DIV128_MASK = 7'h7F;
  localparam logic [PRE_W-1:0] PRE_ONE = 7'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] reserved;
    logic [1:0] windowSel;
    logic [1:0] periodSel;
  } wwd_opt2_t;

  typedef struct packed {
    logic irq;
    logic rst;
  } wwd_event_t;

  typedef enum logic {WWD_STOPPED, WWD_RUNNING} wwd_state_t;

  typedef enum logic [3:0] {
    WWD_R_NONE, WWD_R_REFRESH, WWD_R_START, WWD_R_CONTROL, WWD_R_PROTECT,
    WWD_R_PM_ONE, WWD_R_CLK_ZERO, WWD_R_OPT_TWO, WWD_R_OPT_ONE
  } wwd_reg_t;
endpackage : wwd_pkg

// ---- tb/windowed_watchdog_timer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module windowed_watchdog_timer_test;
  import wwd_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [REG_W-1:0] optionByteOneFlash = 8'hFE;
  wwd_opt2_t watchdogOptionByteTwoFlash = 8'hF0;
  logic flashBlank = 1'b0;
  logic stopMode = 1'b0;
  logic waitMode = 1'b0;
  wwd_event_t wdtEvent;
  logic wdtOscOn;
  logic [1:0] oscDiv = 2'b00;
  wire wdtOscClk = oscDiv[1];
  int cyc = 0;
  int fails = 0;
  int checked = 0;
  logic [1:0] lastResp;
  wwd_event_t lastEv;
  // Latest event pulse and its cycle, so pulses that fall inside a bus task are not lost
  wwd_event_t evSeen = 2'b00;
  int evCyc = 0;
  logic [CNT_W-1:0] inits [4] = '{INIT_P0, INIT_P1, INIT_P2, INIT_P3};

  wwd_windowed_watchdog dut_u (.mclk, .nrst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .optionByteOneFlash, .watchdogOptionByteTwoFlash, .flashBlank, .wdtOscClk,
    .stopMode, .waitMode, .wdtEvent, .wdtOscOn);

  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    oscDiv <= oscDiv + 2'h1;
  end
  always @(negedge mclk) begin
    if (wdtEvent != 2'b00) begin
      evSeen <= wdtEvent;
      evCyc <= cyc;
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  function automatic logic inr(input int n, input int e, input int tol);
    return (n >= e - tol) && (n <= e + tol);
  endfunction : inr

  // Handshakes are judged on the values settled before the rising edge
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic a;
    logic w;
    logic b;
    logic done;
    done = 1'b0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(negedge mclk);
      a = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid & s_axi_bready;
      lastResp = s_axi_bresp;
      @(posedge mclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) begin
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      fails++;
      final_report();
    end else begin
      // Let an edge pass so the next call does not re-raise bready in the same step
      @(posedge mclk);
    end
  endtask : wr

  task automatic rd(input logic [15:0] idx, output logic [7:0] d);
    logic a;
    logic r;
    logic done;
    done = 1'b0;
    d = 8'h00;
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(negedge mclk);
      a = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid & s_axi_rready;
      lastResp = s_axi_rresp;
      d = s_axi_rdata[7:0];
      @(posedge mclk);
      if (a) s_axi_arvalid <= 1'b0;
      if (r) begin
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      fails++;
      final_report();
    end else begin
      @(posedge mclk);
    end
  endtask : rd

  // Counts cycles until an event pulse shows or the limit runs out
  task automatic waitEv(input int lim, output int n);
    n = 0;
    lastEv = 2'b00;
    while (n < lim && lastEv === 2'b00) begin
      @(negedge mclk);
      n++;
      lastEv = wdtEvent;
    end
    @(posedge mclk);
  endtask : waitEv

  task automatic rstDut(input logic [7:0] o1, input logic [7:0] o2, input logic blank);
    nrst <= 1'b0;
    optionByteOneFlash <= o1;
    watchdogOptionByteTwoFlash <= o2;
    flashBlank <= blank;
    stopMode <= 1'b0;
    waitMode <= 1'b0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
  endtask : rstDut

  task automatic t_slice();
    logic [7:0] d;
    logic [5:0] s0;
    int c0;
    int q;
    rstDut(8'hFE, 8'hF0, 1'b0);
    for (int m = 0; m < 2; m++) begin
      wr(IDX_CONTROL, {m[0], 7'h00});
      rd(IDX_CONTROL, d);
      `CHK(d[7:6], {m[0], 1'b0});
      s0 = d[5:0];
      c0 = cyc;
      repeat (m ? 1024 : 320) @(posedge mclk);
      rd(IDX_CONTROL, d);
      q = (cyc - c0) / (m ? 128 : 16);
      `CHK(inr(int'(s0 - d[5:0]), q, 1), 1'b1);
    end
    wr(16'h0001, 8'h12);
    `CHK(lastResp, RESP_SLVERR);
    rd(16'h0001, d);
    `CHK({lastResp, d}, {RESP_SLVERR, 8'h00});
    rd(IDX_OPT_TWO, d);
    `CHK(d, 8'hF0);
  endtask : t_slice

  task automatic t_sweep();
    logic [7:0] d;
    int n;
    for (int p = 1; p < 4; p++) begin
      rstDut(p == 3 ? 8'hFF : 8'hFE, p == 3 ? 8'h00 : {6'h3F, p[1:0]}, p == 3);
      wr(IDX_CLK_ZERO, 8'h80);
      if (p == 3) begin
        rd(IDX_OPT_TWO, d);
        `CHK(d, OPT_ERASED);
        wr(IDX_START, 8'h00);
      end
      waitEv(70000, n);
      `CHK(lastEv, 2'b10);
      `CHK(inr(n, 2 * int'(inits[p]), 10), 1'b1);
    end
  endtask : t_sweep

  task automatic t_window();
    int n;
    int t0;
    int t1;
    int w;
    for (int k = 0; k < 4; k++) begin
      w = 256 * (k + 1);
      rstDut(8'hFE, {4'hF, k[1:0], 2'b00}, 1'b0);
      wr(IDX_CLK_ZERO, 8'h80);
      wr(IDX_PM_ONE, {5'h00, k[0], 2'b00});
      waitEv(3000, n);
      `CHK(lastEv, {~k[0], k[0]});
      t0 = cyc;
      if (k < 3) begin
        while (cyc < t0 + 2 * (1022 - w - 24)) @(posedge mclk);
        t1 = cyc;
        // Refresh before the window opens; this must raise the event
        wr(IDX_REFRESH, REFRESH_FIRST);
        wr(IDX_REFRESH, REFRESH_SECOND);
        waitEv(6, n);
        `CHK({evCyc > t1, evSeen}, {1'b1, ~k[0], k[0]});
      end
      while (cyc < t0 + 2 * (1022 - (k == 3 ? 1000 : w - 24))) @(posedge mclk);
      wr(IDX_REFRESH, REFRESH_FIRST);
      wr(IDX_REFRESH, REFRESH_SECOND);
      waitEv(2200, n);
      `CHK(inr(n, 2046, 10), 1'b1);
    end
  endtask : t_window

  task automatic t_start();
    logic [7:0] d;
    int n;
    rstDut(8'hFF, 8'hF0, 1'b0);
    wr(IDX_CLK_ZERO, 8'h80);
    wr(IDX_OPT_ONE, 8'h00);
    rd(IDX_OPT_ONE, d);
    `CHK(d, 8'hFF);
    waitEv(3000, n);
    `CHK(n, 3000);
    wr(IDX_START, 8'h5A);
    repeat (400) @(posedge mclk);
    stopMode <= 1'b1;
    repeat (600) @(posedge mclk);
    stopMode <= 1'b0;
    waitMode <= 1'b1;
    repeat (600) @(posedge mclk);
    waitMode <= 1'b0;
    waitEv(3000, n);
    `CHK(inr(n + 1600, 2046 + 1200, 10), 1'b1);
    wr(IDX_PROTECT, 8'h80);
    rd(IDX_PROTECT, d);
    `CHK(d[7], 1'b0);
    wr(IDX_PROTECT, 8'h00);
    wr(IDX_PROTECT, 8'h80);
    rd(IDX_PROTECT, d);
    `CHK({d[7], wdtOscOn}, 2'b11);
    rd(IDX_PM_ONE, d);
    `CHK(d[ACTION_BIT], 1'b1);
    wr(IDX_PROTECT, 8'h00);
    rd(IDX_PROTECT, d);
    `CHK(d[7], 1'b1);
  endtask : t_start

  task automatic t_protect();
    logic [7:0] d;
    int n;
    rstDut(8'h7E, 8'hF0, 1'b0);
    @(posedge mclk);
    `CHK(wdtOscOn, 1'b1);
    stopMode <= 1'b1;
    wr(IDX_PM_ONE, 8'h00);
    rd(IDX_PM_ONE, d);
    `CHK(d[ACTION_BIT], 1'b1);
    // The oscillator rises once every four cycles
    waitEv(6000, n);
    `CHK(lastEv, 2'b01);
    `CHK(inr(n, 4 * 1023, 14), 1'b1);
    stopMode <= 1'b0;
  endtask : t_protect

  initial begin
    t_slice();
    t_sweep();
    t_window();
    t_start();
    t_protect();
    final_report();
  end
endmodule : windowed_watchdog_timer_test
`default_nettype wire
